// ==== logic/mtd_defs.vh ====
// Constants of the transmit descriptor manager: register map, fields, limits
`ifndef MTD_DEFS_VH
`define MTD_DEFS_VH

// Register byte offsets (low address byte)
`define MTD_NCR_OFS      8'h00
`define MTD_NCFGR_OFS    8'h04
`define MTD_TSR_OFS      8'h14
`define MTD_TBQP_OFS     8'h1c

// Network control and configuration bits
`define MTD_NCR_TXEN     3
`define MTD_NCR_START    9
`define MTD_NCR_HALT     10
`define MTD_CFG_PAUSE    13

// Transmit status register bits
`define MTD_TSR_USED     0
`define MTD_TSR_RETRY    2
`define MTD_TSR_GO       3
`define MTD_TSR_UNDER    4
`define MTD_TSR_DONE     5
`define MTD_TSR_EXH      6

// Descriptor control word fields
`define MTD_D_OWN        31
`define MTD_D_WRAP       30
`define MTD_D_RETRY      29
`define MTD_D_UNDER      28
`define MTD_D_EXH        27
`define MTD_D_NOCRC      16
`define MTD_D_LAST       15
`define MTD_D_LEN_HI     10

// Descriptor geometry
`define MTD_CTRL_OFS     32'h00000004
`define MTD_DESC_STEP    32'h00000008
`define MTD_DESC_MAX     1024

// Frame length limits in bytes
`define MTD_MIN_FRAME    18'h00040
`define MTD_CRC_BYTES    18'h00004

// Manager states
`define MTD_S_IDLE       4'h0
`define MTD_S_CTRL       4'h1
`define MTD_S_ADDR       4'h2
`define MTD_S_DRD        4'h3
`define MTD_S_EMIT       4'h4
`define MTD_S_NEXT       4'h5
`define MTD_S_PAD        4'h6
`define MTD_S_END        4'h7
`define MTD_S_WAIT       4'h8
`define MTD_S_WB         4'h9

`endif

// ==== logic/mtd_tx_desc_manager.v ====
// Transmit descriptor manager: AHB-Lite registers, descriptor walk, frame byte feed
`timescale 1ns/1ps
`default_nettype none
`include "mtd_defs.vh"

module mtd_tx_desc_manager #(
   parameter DESC_MAX = `MTD_DESC_MAX
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        ce,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   // Memory master request port
   output reg         memReq,
   output reg         memWrite,
   output reg  [31:0] memAddr,
   output reg  [31:0] memWdata,
   input  wire        memAck,
   input  wire        memErr,
   input  wire [31:0] memRdata,
   // Byte feed to transmit engine
   output reg         txValid,
   output reg  [7:0]  txByte,
   input  wire        txReady,
   output reg         txEnd,
   output reg         txNoCrc,
   output reg         txErr,
   output reg         txRunning,
   // Frame outcome from transmit engine
   input  wire        txStatusValid,
   input  wire        txCollision,
   input  wire        txRetryLimit,
   input  wire        txUnderrun,
   input  wire        pauseActive
);

   reg  [3:0]  state;
   reg         txEn;
   reg         pauseEn;
   reg         haltPend;
   reg  [31:0] qBase;
   reg  [31:0] qPtr;
   reg  [9:0]  descCnt;
   reg  [31:0] framePtr;
   reg  [9:0]  frameCnt;
   reg  [31:0] firstCtrl;
   reg  [31:0] bufAddr;
   reg  [31:0] word;
   reg  [10:0] remain;
   reg         lastBuf;
   reg         noCrc;
   reg         curWrap;
   reg         inFrame;
   reg         badEnd;
   reg  [17:0] frameLen;
   reg         stRetry;
   reg         stUnder;
   reg         stExh;
   reg         stkUsed;
   reg         stkRetry;
   reg         stkUnder;
   reg         stkDone;
   reg         stkExh;
   reg         evPend;
   reg         evColl;
   reg         evRetry;
   reg         evUnder;
   reg         apSel;
   reg         apWrite;
   reg  [7:0]  apAddr;

   wire        apTake   = hsel & htrans[1] & hready;
   wire        wrPhase  = apSel & apWrite;
   wire        wrNcr    = wrPhase & (apAddr == `MTD_NCR_OFS);
   wire        wrCfg    = wrPhase & (apAddr == `MTD_NCFGR_OFS);
   wire        wrTsr    = wrPhase & (apAddr == `MTD_TSR_OFS);
   wire        wrTbqp   = wrPhase & (apAddr == `MTD_TBQP_OFS);
   wire        txOff    = wrNcr & ~hwdata[`MTD_NCR_TXEN];
   wire        wrapNow  = curWrap | (descCnt == DESC_MAX - 1);
   wire [7:0]  curByte  = word[{bufAddr[1:0], 3'b000} +: 8];
   wire [17:0] padLimit = `MTD_MIN_FRAME - `MTD_CRC_BYTES;
   wire        inBody   = (state != `MTD_S_IDLE) & (state != `MTD_S_END) &
                          (state != `MTD_S_WB) & (state != `MTD_S_WAIT);

   // Read mux, sampled in the address phase so data stands in the data phase
   reg [31:0] next_hrdata;
   always @* begin
      next_hrdata = 32'h00000000;
      case (haddr[7:0])
         `MTD_NCR_OFS: begin
            next_hrdata[`MTD_NCR_TXEN] = txEn;
         end
         `MTD_NCFGR_OFS: begin
            next_hrdata[`MTD_CFG_PAUSE] = pauseEn;
         end
         `MTD_TSR_OFS: begin
            next_hrdata[`MTD_TSR_USED]  = stkUsed;
            next_hrdata[`MTD_TSR_RETRY] = stkRetry;
            next_hrdata[`MTD_TSR_GO]    = txRunning;
            next_hrdata[`MTD_TSR_UNDER] = stkUnder;
            next_hrdata[`MTD_TSR_DONE]  = stkDone;
            next_hrdata[`MTD_TSR_EXH]   = stkExh;
         end
         `MTD_TBQP_OFS: begin
            next_hrdata = qPtr;
         end
         default: begin
            next_hrdata = 32'h00000000;
         end
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         apSel     <= 1'b0;
         apWrite   <= 1'b0;
         apAddr    <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         apSel   <= apTake;
         apWrite <= hwrite;
         apAddr  <= haddr[7:0];
         if (apTake & ~hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // Descriptor walker, run flag and status
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state     <= `MTD_S_IDLE;
         txEn      <= 1'b0;
         pauseEn   <= 1'b0;
         haltPend  <= 1'b0;
         qBase     <= 32'h00000000;
         qPtr      <= 32'h00000000;
         descCnt   <= 10'h000;
         framePtr  <= 32'h00000000;
         frameCnt  <= 10'h000;
         firstCtrl <= 32'h00000000;
         bufAddr   <= 32'h00000000;
         word      <= 32'h00000000;
         remain    <= 11'h000;
         lastBuf   <= 1'b0;
         noCrc     <= 1'b0;
         curWrap   <= 1'b0;
         inFrame   <= 1'b0;
         badEnd    <= 1'b0;
         frameLen  <= 18'h00000;
         stRetry   <= 1'b0;
         stUnder   <= 1'b0;
         stExh     <= 1'b0;
         stkUsed   <= 1'b0;
         stkRetry  <= 1'b0;
         stkUnder  <= 1'b0;
         stkDone   <= 1'b0;
         stkExh    <= 1'b0;
         evPend    <= 1'b0;
         evColl    <= 1'b0;
         evRetry   <= 1'b0;
         evUnder   <= 1'b0;
         memReq    <= 1'b0;
         memWrite  <= 1'b0;
         memAddr   <= 32'h00000000;
         memWdata  <= 32'h00000000;
         txValid   <= 1'b0;
         txByte    <= 8'h00;
         txEnd     <= 1'b0;
         txNoCrc   <= 1'b0;
         txErr     <= 1'b0;
         txRunning <= 1'b0;
      end else if (ce) begin
         txEnd <= 1'b0;
         // Sticky status: write one clears, a new event in the same cycle wins
         if (wrTsr) begin
            if (hwdata[`MTD_TSR_USED])  stkUsed  <= 1'b0;
            if (hwdata[`MTD_TSR_RETRY]) stkRetry <= 1'b0;
            if (hwdata[`MTD_TSR_UNDER]) stkUnder <= 1'b0;
            if (hwdata[`MTD_TSR_DONE])  stkDone  <= 1'b0;
            if (hwdata[`MTD_TSR_EXH])   stkExh   <= 1'b0;
         end
         if (wrCfg) begin
            pauseEn <= hwdata[`MTD_CFG_PAUSE];
         end
         if (wrNcr) begin
            txEn <= hwdata[`MTD_NCR_TXEN];
            if (hwdata[`MTD_NCR_START] & hwdata[`MTD_NCR_TXEN]) begin
               txRunning <= 1'b1;
            end
            if (hwdata[`MTD_NCR_HALT]) begin
               haltPend <= 1'b1;
            end
         end
         // Engine outcome held until the walker can act on it
         if (txStatusValid) begin
            evPend  <= 1'b1;
            evColl  <= txCollision;
            evRetry <= txRetryLimit;
            evUnder <= txUnderrun;
         end

         case (state)
            `MTD_S_IDLE: begin
               inFrame <= 1'b0;
               evPend  <= txStatusValid;
               if (haltPend) begin
                  txRunning <= 1'b0;
                  haltPend  <= 1'b0;
               end else if (txRunning & txEn & ~(pauseEn & pauseActive)) begin
                  framePtr <= qPtr;
                  frameCnt <= descCnt;
                  frameLen <= 18'h00000;
                  stRetry  <= 1'b0;
                  stUnder  <= 1'b0;
                  stExh    <= 1'b0;
                  badEnd   <= 1'b0;
                  state    <= `MTD_S_CTRL;
               end
            end
            `MTD_S_CTRL: begin
               if (~memReq) begin
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memAddr  <= qPtr + `MTD_CTRL_OFS;
               end else if (memAck) begin
                  memReq <= 1'b0;
                  if (memErr) begin
                     stUnder <= 1'b1;
                     badEnd  <= 1'b1;
                     state   <= inFrame ? `MTD_S_END : `MTD_S_WB;
                  end else if (memRdata[`MTD_D_OWN]) begin
                     if (inFrame) begin
                        stExh   <= 1'b1;
                        stUnder <= 1'b1;
                        badEnd  <= 1'b1;
                        state   <= `MTD_S_END;
                     end else begin
                        txRunning <= 1'b0;
                        stkUsed   <= 1'b1;
                        state     <= `MTD_S_IDLE;
                     end
                  end else begin
                     remain  <= memRdata[`MTD_D_LEN_HI:0];
                     lastBuf <= memRdata[`MTD_D_LAST];
                     noCrc   <= memRdata[`MTD_D_NOCRC];
                     curWrap <= memRdata[`MTD_D_WRAP];
                     if (~inFrame) begin
                        firstCtrl <= memRdata;
                     end
                     inFrame <= 1'b1;
                     state   <= `MTD_S_ADDR;
                  end
               end
            end
            `MTD_S_ADDR: begin
               if (~memReq) begin
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memAddr  <= qPtr;
               end else if (memAck) begin
                  memReq  <= 1'b0;
                  bufAddr <= memRdata;
                  if (memErr) begin
                     stUnder <= 1'b1;
                     badEnd  <= 1'b1;
                     state   <= `MTD_S_END;
                  end else begin
                     // Empty buffer goes straight on to the next descriptor
                     state <= (remain == 11'h000) ? `MTD_S_NEXT : `MTD_S_DRD;
                  end
               end
            end
            `MTD_S_DRD: begin
               if (~memReq) begin
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memAddr  <= {bufAddr[31:2], 2'b00};
               end else if (memAck) begin
                  memReq <= 1'b0;
                  word   <= memRdata;
                  if (memErr) begin
                     stUnder <= 1'b1;
                     badEnd  <= 1'b1;
                     state   <= `MTD_S_END;
                  end else begin
                     state <= `MTD_S_EMIT;
                  end
               end
            end
            `MTD_S_EMIT: begin
               // One byte per handshake; a word is refetched only at its end
               if (~txValid) begin
                  txValid <= 1'b1;
                  txByte  <= curByte;
               end else if (txReady) begin
                  txValid  <= 1'b0;
                  bufAddr  <= bufAddr + 32'h00000001;
                  remain   <= remain - 11'h001;
                  frameLen <= frameLen + 18'h00001;
                  if (remain == 11'h001) begin
                     state <= `MTD_S_NEXT;
                  end else if (bufAddr[1:0] == 2'b11) begin
                     state <= `MTD_S_DRD;
                  end
               end
            end
            `MTD_S_NEXT: begin
               if (wrapNow) begin
                  qPtr    <= qBase;
                  descCnt <= 10'h000;
               end else begin
                  qPtr    <= qPtr + `MTD_DESC_STEP;
                  descCnt <= descCnt + 10'h001;
               end
               if (~lastBuf) begin
                  state <= `MTD_S_CTRL;
               end else if (~noCrc & (frameLen < padLimit)) begin
                  state <= `MTD_S_PAD;
               end else begin
                  state <= `MTD_S_END;
               end
            end
            `MTD_S_PAD: begin
               // Zero fill so the engine's CRC lands at the minimum size
               if (~txValid) begin
                  txValid <= 1'b1;
                  txByte  <= 8'h00;
               end else if (txReady) begin
                  txValid  <= 1'b0;
                  frameLen <= frameLen + 18'h00001;
                  if (frameLen == padLimit - 18'h00001) begin
                     state <= `MTD_S_END;
                  end
               end
            end
            `MTD_S_END: begin
               txValid <= 1'b0;
               txEnd   <= 1'b1;
               txNoCrc <= noCrc & ~badEnd;
               txErr   <= badEnd;
               state   <= badEnd ? `MTD_S_WB : `MTD_S_WAIT;
            end
            `MTD_S_WAIT: begin
               if (evPend) begin
                  evPend <= txStatusValid;
                  if (evColl & ~evRetry) begin
                     qPtr     <= framePtr;
                     descCnt  <= frameCnt;
                     frameLen <= 18'h00000;
                     inFrame  <= 1'b0;
                     state    <= `MTD_S_CTRL;
                  end else begin
                     stRetry <= evRetry;
                     stUnder <= evUnder;
                     state   <= `MTD_S_WB;
                  end
               end
            end
            `MTD_S_WB: begin
               txErr <= 1'b0;
               if (~memReq) begin
                  memReq   <= 1'b1;
                  memWrite <= 1'b1;
                  memAddr  <= framePtr + `MTD_CTRL_OFS;
                  memWdata <= {~(stRetry | stUnder | stExh), firstCtrl[`MTD_D_WRAP],
                               stRetry, stUnder, stExh, firstCtrl[26:0]};
               end else if (memAck) begin
                  memReq   <= 1'b0;
                  memWrite <= 1'b0;
                  inFrame  <= 1'b0;
                  if (stRetry) stkRetry <= 1'b1;
                  if (stUnder) stkUnder <= 1'b1;
                  if (stExh)   stkExh   <= 1'b1;
                  if (stRetry | stUnder | stExh) begin
                     qPtr      <= qBase;
                     descCnt   <= 10'h000;
                     txRunning <= 1'b0;
                  end else begin
                     stkDone <= 1'b1;
                  end
                  state <= `MTD_S_IDLE;
               end
            end
            default: begin
               state <= `MTD_S_IDLE;
            end
         endcase

         // Engine outcome arriving while buffers are still being fed
         if (inBody & evPend & ~memReq) begin
            evPend  <= txStatusValid;
            txValid <= 1'b0;
            if (evColl & ~evRetry) begin
               qPtr     <= framePtr;
               descCnt  <= frameCnt;
               frameLen <= 18'h00000;
               inFrame  <= 1'b0;
               state    <= `MTD_S_CTRL;
            end else begin
               stRetry <= evRetry;
               stUnder <= evUnder;
               state   <= `MTD_S_WB;
            end
         end

         // Pointer write and transmit disable override any walk in progress
         if (wrTbqp) begin
            qBase     <= hwdata;
            qPtr      <= hwdata;
            descCnt   <= 10'h000;
            txRunning <= 1'b0;
         end else if (txOff) begin
            qPtr      <= qBase;
            descCnt   <= 10'h000;
            txRunning <= 1'b0;
         end
         if (wrTbqp | txOff) begin
            state    <= `MTD_S_IDLE;
            memReq   <= 1'b0;
            memWrite <= 1'b0;
            txValid  <= 1'b0;
            inFrame  <= 1'b0;
            haltPend <= 1'b0;
         end
      end
   end

endmodule // mtd_tx_desc_manager

`default_nettype wire

// ==== sim/mtd_mem_model.sv ====
// System memory stand-in answering the manager's word requests
`timescale 1ns/1ps
`default_nettype none
module mtd_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memWdata,
   input  wire logic [3:0]  lag,
   input  wire logic [31:0] errAddr,
   output logic             memAck,
   output logic             memErr,
   output logic [31:0]      memRdata
);
   logic [31:0] mem [0:255];
   logic [3:0]  waited;
   // Answer after lag cycles; data between answers toggles so stale words never look valid
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         memAck   <= 1'b0;
         memErr   <= 1'b0;
         memRdata <= 32'h00000000;
         waited   <= 4'h0;
      end else begin
         memAck   <= 1'b0;
         memErr   <= 1'b0;
         memRdata <= ~memRdata;
         waited   <= 4'h0;
         if (memReq && !memAck) begin
            if (waited < lag) begin
               waited <= waited + 4'h1;
            end else begin
               memAck <= 1'b1;
               memErr <= memAddr == errAddr;
               if (memWrite) mem[memAddr[9:2]] <= memWdata;
               else memRdata <= mem[memAddr[9:2]];
            end
         end
      end
   end
endmodule // mtd_mem_model
`default_nettype wire

// ==== sim/mtd_tx_desc_manager_checker.sv ====
// Port assertions for the transmit descriptor manager
`timescale 1ns/1ps
`default_nettype none
module mtd_checker #(
   parameter int DESC_MAX = 1024
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        memReq,
   input wire logic        memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memWdata,
   input wire logic        memAck,
   input wire logic        txValid,
   input wire logic [7:0]  txByte,
   input wire logic        txReady,
   input wire logic        txEnd,
   input wire logic        txNoCrc,
   input wire logic        txErr,
   input wire logic        txRunning
);
   logic        ctlWr;
   logic [15:0] fed;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Control write seen in address phase; bytes taken since the last frame end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctlWr <= 1'b0;
         fed   <= 16'h0000;
      end else begin
         ctlWr <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
         fed   <= txEnd ? 16'h0000 : fed + {15'h0000, txValid && txReady};
      end
   end
   a_start_cause: assert property ($rose(txRunning) |-> $past(ctlWr) && $past(hwdata[9]))
      else $error("run flag rose without a start write");
   a_wb_ctrl: assert property (memReq && memWrite |-> memAddr[2:0] == 3'h4)
      else $error("write-back not aimed at a control word");
   a_wb_used: assert property (memReq && memWrite && memWdata[31] |-> memWdata[29:27] == 3'h0)
      else $error("used bit written with error status");
   a_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
      else $error("memory request dropped or moved");
   a_byte_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
      else $error("byte changed before it was taken");
   a_end_pulse: assert property (txEnd |=> !txEnd)
      else $error("frame end longer than one cycle");
   a_pad_min: assert property (txEnd && !txNoCrc && !txErr |-> fed >= 16'h003c)
      else $error("frame with CRC shorter than 60 bytes");
   a_err_stop: assert property (txEnd && txErr |-> ##[1:40] !txRunning)
      else $error("run flag kept after an aborted frame");
   c_abort: cover property (txEnd && txErr);
   c_used_wb: cover property (memReq && memWrite && memWdata[31]);
   c_halted: cover property ($fell(txRunning));
endmodule // mtd_checker
`default_nettype wire

// ==== sim/tb.sv ====
// Testbench: register access, descriptor walks and frame outcomes
`timescale 1ns/1ps
`default_nettype none
`include "mtd_defs.vh"
module tb;
   logic        clk_sys = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, txReady = 1'b0;
   logic        txStatusValid = 1'b0, txCollision = 1'b0, pauseActive = 1'b0, colOnce = 1'b0;
   logic        lastErr, lastNoCrc;
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  lag = 4'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, errAddr = 32'hffffffff, q;
   logic [7:0]  got[$];
   wire         hready, hresp, memReq, memWrite, memAck, memErr, txValid, txEnd, txNoCrc, txErr, txRunning;
   wire  [31:0] hrdata, memAddr, memWdata, memRdata;
   wire  [7:0]  txByte;
   int          ends = 0, e0 = 0, fails = 0, checked = 0;
   mtd_tx_desc_manager #(.DESC_MAX(4)) i_mtd_tx_desc_manager (
      .clk_sys, .reset, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hreadyout(hready), .hresp, .hrdata, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memErr,
      .memRdata, .txValid, .txByte, .txReady, .txEnd, .txNoCrc, .txErr, .txRunning, .txStatusValid,
      .txCollision, .txRetryLimit(1'b0), .txUnderrun(1'b0), .pauseActive);
   mtd_mem_model i_mtd_mem_model (.clk_sys, .reset, .memReq, .memWrite, .memAddr, .memWdata, .lag,
      .errAddr, .memAck, .memErr, .memRdata);
   // 100 MHz system clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // Engine stand-in: ready toggles to stall; outcome one cycle after frame end
   always @(posedge clk_sys) begin
      txReady <= ~txReady;
      txStatusValid <= txEnd;
      if (txValid && txReady) got.push_back(txByte);
      if (txEnd) begin
         ends <= ends + 1;
         lastErr <= txErr;
         lastNoCrc <= txNoCrc;
         txCollision <= colOnce;
         colOnce <= 1'b0;
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Single word: address phase until ready, then data phase; read data taken at its last edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic start;
      bus(`MTD_NCR_OFS, 1'b1, 32'h00000208);
   endtask
   // Descriptor in memory: buffer address word, then control word
   task automatic desc(input int a, input logic [31:0] bufAddr, input logic [31:0] ctrl);
      i_mtd_mem_model.mem[a / 4] = bufAddr;
      i_mtd_mem_model.mem[a / 4 + 1] = ctrl;
   endtask
   function automatic logic [31:0] mw(input int i);
      return i_mtd_mem_model.mem[i];
   endfunction
   // New queue; pointer written only while stopped
   task automatic go(input logic [31:0] base);
      got.delete();
      e0 = ends;
      bus(`MTD_TBQP_OFS, 1'b1, base);
   endtask
   task automatic waitIdle;
      do @(negedge clk_sys); while (txRunning !== 1'b0 || memReq !== 1'b0);
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, far above the roughly one thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      rd(`MTD_TSR_OFS);
      check(q[3], 1'b0, "run at reset");
      rd(8'h40);
      check({q, hresp}, 33'h0, "unmapped");
      $display("done registers");
      // Three buffers, middle one empty, then an owned descriptor
      desc(0, 32'h100, 32'h00000003);
      desc(8, 32'h104, 32'h00000000);
      desc(16, 32'h108, 32'h00008002);
      desc(24, 32'h10c, 32'h80000000);
      desc(32, 32'h10c, 32'h80000000);
      i_mtd_mem_model.mem[64] = 32'h44332211;
      i_mtd_mem_model.mem[66] = 32'h00006655;
      go(32'h0);
      start();
      waitIdle();
      check(got.size(), 60, "padded len");
      check({got[0], got[1], got[2], got[3], got[4]}, 40'h1122335566, "bytes");
      check(got[5] | got[59], 8'h00, "pad");
      check(mw(1), 32'h80000003, "wb first");
      check(mw(5), 32'h00008002, "wb last");
      rd(`MTD_TSR_OFS);
      check({q[3], q[0]}, 2'h1, "owned stop");
      rd(`MTD_TBQP_OFS);
      check(q, 32'h18, "kept ptr");
      $display("done chain");
      // Resume at kept descriptor, no CRC, then roll over after four descriptors
      desc(24, 32'h10c, 32'h00018001);
      i_mtd_mem_model.mem[67] = 32'h00000077;
      got.delete();
      start();
      waitIdle();
      check({got.size(), got[0], lastNoCrc}, {32'h1, 8'h77, 1'b1}, "resume nocrc");
      check(mw(7), 32'h80018001, "wb resume");
      rd(`MTD_TBQP_OFS);
      check(q, 32'h0, "rollover");
      $display("done resume");
      // Collision on a two-buffer frame whose last descriptor wraps
      desc(64, 32'h100, 32'h00000004);
      desc(72, 32'h104, 32'h40008000);
      desc(80, 32'h10c, 32'h80000000);
      colOnce <= 1'b1;
      go(32'h40);
      rd(`MTD_TBQP_OFS);
      check(q, 32'h40, "ptr write");
      start();
      waitIdle();
      check(ends - e0, 2, "attempts");
      check({got[60], got[61], got[62], got[63]}, 32'h11223344, "restart");
      check(mw(17), 32'h80000004, "wb collide");
      rd(`MTD_TBQP_OFS);
      check(q, 32'h40, "wrap");
      $display("done collision");
      // Owned descriptor in mid-frame; queue rebuilt first
      desc(64, 32'h100, 32'h00000004);
      desc(72, 32'h104, 32'h80000000);
      go(32'h40);
      start();
      waitIdle();
      check(lastErr, 1'b1, "abort");
      check(mw(17), 32'h18000004, "wb exhausted");
      rd(`MTD_TSR_OFS);
      check({q[6], q[4], q[3]}, 3'h6, "error status");
      rd(`MTD_TBQP_OFS);
      check(q, 32'h40, "error rewind");
      $display("done error");
      // Halt during a slow frame, then disable
      desc(64, 32'h100, 32'h00008004);
      desc(72, 32'h100, 32'h00008004);
      lag <= 4'h3;
      go(32'h40);
      start();
      bus(`MTD_NCR_OFS, 1'b1, 32'h00000408);
      waitIdle();
      check({ends - e0, mw(17)}, {32'h1, 32'h80008004}, "halt after frame");
      rd(`MTD_TBQP_OFS);
      check(q, 32'h48, "halt ptr");
      bus(`MTD_NCR_OFS, 1'b1, 32'h0);
      rd(`MTD_TBQP_OFS);
      check(q, 32'h40, "disable rewind");
      lag <= 4'h0;
      $display("done halt");
      // Pause holds the frame; its data fetch then meets a bus error
      bus(`MTD_NCFGR_OFS, 1'b1, 32'h00002000);
      pauseActive <= 1'b1;
      errAddr <= 32'h100;
      bus(`MTD_TSR_OFS, 1'b1, 32'h0000007f);
      desc(64, 32'h100, 32'h00008004);
      go(32'h40);
      start();
      repeat (30) @(posedge clk_sys);
      rd(`MTD_TSR_OFS);
      check({ends - e0, q[4:3]}, {32'h0, 2'h1}, "paused");
      pauseActive <= 1'b0;
      waitIdle();
      check(mw(17) >> 27, 32'h2, "wb bus error");
      rd(`MTD_TSR_OFS);
      check({q[4], q[3]}, 2'h2, "underrun stop");
      $display("done pause");
      conclude();
   end
endmodule // tb
bind mtd_tx_desc_manager mtd_checker #(.DESC_MAX(DESC_MAX)) i_mtd_checker (
   .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .memReq, .memWrite, .memAddr,
   .memWdata, .memAck, .txValid, .txByte, .txReady, .txEnd, .txNoCrc, .txErr, .txRunning);
`default_nettype wire
